// ===== hdl/fscr_pkg.sv
// Constants, field layouts and carrier types for the flash status and configuration register bank.
package fscr_pkg;

    // ------------------------------------------------------------------
    // Command opcodes seen on the serial link
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_REGS = 8'h01;
    localparam logic [7:0] OPC_READ_STATUS_TWO = 8'h07;
    localparam logic [7:0] OPC_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OPC_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] OPC_READ_ANY_REG = 8'h65;
    localparam logic [7:0] OPC_WRITE_ANY_REG = 8'h71;

    // ------------------------------------------------------------------
    // Frame lengths in link clock edges, counted from the first opcode bit
    // ------------------------------------------------------------------
    localparam logic [5:0] LEN_OPCODE = 6'h08;
    localparam logic [5:0] LEN_WRITE_REGS = 6'h18;
    localparam logic [5:0] LEN_READ_ADDR = 6'h20;
    localparam logic [5:0] LEN_WRITE_ANY = 6'h28;

    // ------------------------------------------------------------------
    // Register addresses used by the read-any and write-any commands
    // ------------------------------------------------------------------
    localparam logic [23:0] ADDR_STATUS_TWO_VOLATILE = 24'h800001;
    localparam logic [23:0] ADDR_CONFIG_ONE_PERSISTENT = 24'h000002;

    // ------------------------------------------------------------------
    // Status register two field positions
    // ------------------------------------------------------------------
    localparam int SR2_ERASE_FAIL = 6;
    localparam int SR2_PROG_FAIL = 5;
    localparam int SR2_ERASE_HALT = 1;
    localparam int SR2_PROG_HALT = 0;

    // ------------------------------------------------------------------
    // Persistent configuration register one field positions
    // ------------------------------------------------------------------
    localparam int CR1_HALT_STATUS_DEFAULT = 7;
    localparam int CR1_INVERT_MAP_DEFAULT = 6;
    localparam int CR1_REGION_LOCK_LSB = 2;
    localparam int CR1_FOUR_LANE_DEFAULT = 1;
    localparam int CR1_REG_LOCK_DEFAULT = 0;
    localparam logic [2:0] SCHEME_ALL_ONES = 3'h7;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_STATUS_TWO = 8'h00;
    localparam logic [7:0] RST_CONFIG_ONE_PERSISTENT = 8'h00;

    // One decoded command handed from the link domain to the core.
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [15:0] data;
    } fscr_cmd_t;

    // Volatile copies that the rest of the device runs on.
    typedef struct packed {
        logic halt_status;
        logic inverted_protect_map;
        logic [3:0] region_lock;
        logic four_lane;
        logic reg_lock_one;
    } fscr_live_t;

endpackage : fscr_pkg

// ===== hdl/fscr_regs.sv
// Status register two and persistent configuration register one of a serial flash, with a link front end.
`timescale 1ns/1ns
// Function
// - Return status register two on read-status-two or read-any-register command.
// - Status register two bits 7, 4, 3, 2 always read zero.
// - Set erase failure flag, bit 6, when the last erase failed.
// - Erase of a protected sector or locked region also sets erase failure.
// - Protected sector found during chip erase sets erase failure.
// - Set program failure flag, bit 5, when the last program failed.
// - Program in a protected sector or locked region sets program failure.
// - Only the clear-status command clears either failure flag.
// - Register write commands leave both failure flags unchanged.
// - Bit 1 reads one while an erase is suspended.
// - Bit 0 reads one while a program is suspended.
// - Suspend bits ignore user writes; only internal suspend state moves them.
// - Accept configuration writes by write-registers (sixteen data bits) or write-any-register.
// - Persistent configuration writes need the preceding write-permit command.
// - Bit 7 gives the suspend status default and cannot be programmed.
// - Bit 6 gives the inverted protection map default.
// - Bits 5 to 2 lock four security regions once set, permanently.
// - Bit 1 is writable and gives the four-lane default after reset.
// - Bit 0 gives the register-lock default.
// - Register-lock default is programmable only while scheme field is all ones.
// - Register-lock default one rejects all register writes permanently.
// - Program, write and erase are refused unless the write-permit latch is one.
// - Any failure flag keeps busy at one and refuses operations until cleared.
module fscr_regs #(
    parameter int REGION_COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic soft_reset_req,
    input wire logic [2:0] protection_scheme_select,
    input wire logic engine_busy,
    input wire logic [1:0] op_req,
    input wire logic [1:0] op_prot_hit,
    input wire logic [1:0] op_region_hit,
    input wire logic [3:0] op_region_idx,
    input wire logic [1:0] op_fail,
    input wire logic [1:0] op_done,
    input wire logic [1:0] op_halted,
    output logic [1:0] op_go,
    output logic [7:0] status_two_volatile,
    output logic [7:0] config_one_persistent,
    output fscr_pkg::fscr_live_t live_cfg,
    output logic busy_flag,
    output logic write_permit_latch
);
    import fscr_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The lock field has exactly four bits in the register, so nothing else fits.
    if (REGION_COUNT != 4) begin : g_bad_region_count
        $error("fscr_regs supports exactly four security regions.");
    end

    // ------------------------------------------------------------------
    // Link domain: receive
    // ------------------------------------------------------------------
    logic [5:0] bit_cnt_q;
    logic [38:0] shift_q;
    logic [7:0] opcode_q;
    logic [23:0] rd_addr_q;
    fscr_cmd_t cmd_hold_q;
    logic cmd_tgl_q;
    logic [15:0] mirror_q;
    logic [7:0] rd_byte;

    // Chip select high clears the frame state, since the link clock stands still between frames.
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            bit_cnt_q <= 6'h00;
            shift_q <= 39'h0;
            opcode_q <= 8'h00;
            rd_addr_q <= 24'h000000;
        end else begin
            shift_q <= {shift_q[37:0], mosi};
            if (bit_cnt_q != 6'h3f) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q == LEN_OPCODE - 6'h01) begin
                opcode_q <= {shift_q[6:0], mosi};
            end
            if (bit_cnt_q == LEN_READ_ADDR - 6'h01) begin
                rd_addr_q <= {shift_q[22:0], mosi};
            end
        end
    end

    // A completed command is parked here and announced by a toggle; it stays put for the next
    // command's whole opcode, far longer than the core needs to take it.
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_hold_q <= '0;
            cmd_tgl_q <= 1'b0;
        end else if (!cs_b) begin
            if (bit_cnt_q == LEN_OPCODE - 6'h01 && ({shift_q[6:0], mosi} == OPC_WRITE_PERMIT ||
                {shift_q[6:0], mosi} == OPC_CLEAR_STATUS)) begin
                cmd_hold_q <= '{opcode: {shift_q[6:0], mosi}, addr: 24'h000000, data: 16'h0000};
                cmd_tgl_q <= ~cmd_tgl_q;
            end else if (bit_cnt_q == LEN_WRITE_REGS - 6'h01 && opcode_q == OPC_WRITE_REGS) begin
                cmd_hold_q <= '{opcode: opcode_q, addr: 24'h000000, data: {shift_q[14:0], mosi}};
                cmd_tgl_q <= ~cmd_tgl_q;
            end else if (bit_cnt_q == LEN_WRITE_ANY - 6'h01 && opcode_q == OPC_WRITE_ANY_REG) begin
                cmd_hold_q <= '{opcode: opcode_q, addr: shift_q[30:7], data: {8'h00, shift_q[6:0], mosi}};
                cmd_tgl_q <= ~cmd_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Link domain: transmit
    // ------------------------------------------------------------------
    // The mirror is frozen for the length of a frame, so it is steady whenever the link reads it.
    always_comb begin
        rd_byte = 8'h00;
        if (opcode_q == OPC_READ_STATUS_TWO) begin
            rd_byte = mirror_q[15:8];
        end else if (rd_addr_q == ADDR_STATUS_TWO_VOLATILE) begin
            rd_byte = mirror_q[15:8];
        end else if (rd_addr_q == ADDR_CONFIG_ONE_PERSISTENT) begin
            rd_byte = mirror_q[7:0];
        end
    end

    // Data leaves on the falling edge, most significant bit first, and repeats per byte.
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else if ((opcode_q == OPC_READ_STATUS_TWO && bit_cnt_q >= LEN_OPCODE) ||
                     (opcode_q == OPC_READ_ANY_REG && bit_cnt_q >= LEN_READ_ADDR)) begin
            miso <= rd_byte[3'h7 - bit_cnt_q[2:0]];
            miso_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the core clock
    // ------------------------------------------------------------------
    logic cs_meta_q;
    logic cs_sync_q;
    logic tgl_meta_q;
    logic tgl_sync_q;
    logic tgl_seen_q;
    logic pending_q;
    fscr_cmd_t cmd_q;

    // Two-stage synchronisers for chip select and the command toggle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            tgl_meta_q <= 1'b0;
            tgl_sync_q <= 1'b0;
        end else begin
            cs_meta_q <= cs_b;
            cs_sync_q <= cs_meta_q;
            tgl_meta_q <= cmd_tgl_q;
            tgl_sync_q <= tgl_meta_q;
        end
    end

    // Commands take effect only once the frame has ended, as the link protocol expects.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgl_seen_q <= 1'b0;
            pending_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            if (tgl_sync_q != tgl_seen_q) begin
                tgl_seen_q <= tgl_sync_q;
                cmd_q <= cmd_hold_q;
                pending_q <= 1'b1;
            end else if (pending_q && cs_sync_q) begin
                pending_q <= 1'b0;
            end
        end
    end

    // Read mirror refreshes only between frames.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mirror_q <= {RST_STATUS_TWO, RST_CONFIG_ONE_PERSISTENT};
        end else if (cs_sync_q) begin
            mirror_q <= {status_two_volatile, config_one_persistent};
        end
    end

    // ------------------------------------------------------------------
    // Core: command decode
    // ------------------------------------------------------------------
    logic loaded_q;
    logic exec;
    logic do_permit;
    logic do_clear;
    logic write_cr1;
    logic [7:0] wr_byte;
    logic regs_locked;
    logic [1:0] grant;
    logic [1:0] refuse_err;
    logic [1:0] lock_hit;

    assign exec = pending_q && cs_sync_q && loaded_q && tgl_sync_q == tgl_seen_q;
    // While busy only the clear-status command gets through.
    assign do_permit = exec && cmd_q.opcode == OPC_WRITE_PERMIT && !busy_flag;
    assign do_clear = exec && cmd_q.opcode == OPC_CLEAR_STATUS;
    assign regs_locked = live_cfg.reg_lock_one || config_one_persistent[CR1_REG_LOCK_DEFAULT];
    assign wr_byte = (cmd_q.opcode == OPC_WRITE_REGS) ? cmd_q.data[7:0] : cmd_q.data[7:0];
    // Writes aimed at status register two fall through this decode and change nothing.
    assign write_cr1 = exec && !busy_flag && write_permit_latch && !regs_locked &&
        (cmd_q.opcode == OPC_WRITE_REGS ||
         (cmd_q.opcode == OPC_WRITE_ANY_REG && cmd_q.addr == ADDR_CONFIG_ONE_PERSISTENT));

    // Operation gate; an erase request wins over a program request in the same cycle.
    always_comb begin
        grant = 2'b00;
        refuse_err = 2'b00;
        lock_hit = 2'b00;
        for (int i = 0; i < 2; i++) begin
            lock_hit[i] = op_region_hit[i] &&
                config_one_persistent[CR1_REGION_LOCK_LSB + int'(op_region_idx[2*i +: 2])];
            if (op_req[i] && loaded_q && write_permit_latch && !busy_flag &&
                !(i == 0 && op_req[1])) begin
                if (op_prot_hit[i] || lock_hit[i]) begin
                    refuse_err[i] = 1'b1;
                end else begin
                    grant[i] = 1'b1;
                end
            end
        end
    end

    // Start pulses to the embedded-operation engine.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_go <= 2'b00;
        end else begin
            op_go <= grant;
        end
    end

    // ------------------------------------------------------------------
    // Core: status register two and busy
    // ------------------------------------------------------------------
    logic [1:0] fail_d;

    // A failure arriving together with a clear-status still leaves the flag set.
    always_comb begin
        fail_d = {status_two_volatile[SR2_ERASE_FAIL], status_two_volatile[SR2_PROG_FAIL]};
        if (do_clear) begin
            fail_d = 2'b00;
        end
        fail_d = fail_d | op_fail | refuse_err;
    end

    // Reserved bits are tied low; suspend bits follow the engine only.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_two_volatile <= RST_STATUS_TWO;
        end else begin
            status_two_volatile <= 8'h00;
            status_two_volatile[SR2_ERASE_FAIL] <= fail_d[1];
            status_two_volatile[SR2_PROG_FAIL] <= fail_d[0];
            status_two_volatile[SR2_ERASE_HALT] <= op_halted[1];
            status_two_volatile[SR2_PROG_HALT] <= op_halted[0];
        end
    end

    // Busy stays up as long as a failure flag is standing.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= engine_busy || grant != 2'b00 || fail_d != 2'b00;
        end
    end

    // Write-permit latch: set by its command, dropped by clear-status or a successful write or operation.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_permit_latch <= 1'b0;
        end else if (do_clear || write_cr1 || (op_done & ~op_fail) != 2'b00) begin
            write_permit_latch <= 1'b0;
        end else if (do_permit) begin
            write_permit_latch <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Core: persistent configuration register one
    // ------------------------------------------------------------------
    // The halt default is never programmed; lock bits only go from zero to one.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            config_one_persistent <= RST_CONFIG_ONE_PERSISTENT;
        end else if (write_cr1) begin
            config_one_persistent[CR1_INVERT_MAP_DEFAULT] <= wr_byte[CR1_INVERT_MAP_DEFAULT];
            config_one_persistent[CR1_REGION_LOCK_LSB +: 4] <= config_one_persistent[CR1_REGION_LOCK_LSB +: 4] |
                wr_byte[CR1_REGION_LOCK_LSB +: 4];
            config_one_persistent[CR1_FOUR_LANE_DEFAULT] <= wr_byte[CR1_FOUR_LANE_DEFAULT];
            if (protection_scheme_select == SCHEME_ALL_ONES) begin
                config_one_persistent[CR1_REG_LOCK_DEFAULT] <= config_one_persistent[CR1_REG_LOCK_DEFAULT] |
                    wr_byte[CR1_REG_LOCK_DEFAULT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Core: volatile copies and the load after reset
    // ------------------------------------------------------------------
    // Defaults are copied on the first edge after release, and again on a software reset,
    // which spares the register lock so that only a hardware reset can drop it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loaded_q <= 1'b0;
            live_cfg <= '0;
        end else begin
            loaded_q <= 1'b1;
            live_cfg.region_lock <= config_one_persistent[CR1_REGION_LOCK_LSB +: 4];
            if (!loaded_q || soft_reset_req) begin
                live_cfg.inverted_protect_map <= config_one_persistent[CR1_INVERT_MAP_DEFAULT];
                live_cfg.four_lane <= config_one_persistent[CR1_FOUR_LANE_DEFAULT];
                live_cfg.halt_status <= config_one_persistent[CR1_HALT_STATUS_DEFAULT];
                if (!loaded_q) begin
                    live_cfg.reg_lock_one <= config_one_persistent[CR1_REG_LOCK_DEFAULT];
                end
            end else begin
                live_cfg.halt_status <= op_halted != 2'b00;
            end
        end
    end

endmodule : fscr_regs

// ===== sim/fscr_regs_props.sv
// Concurrent checks on the ports of the status and configuration register bank.
`timescale 1ns/1ns
module fscr_regs_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic soft_reset_req,
    input wire logic [1:0] op_req,
    input wire logic [1:0] op_prot_hit,
    input wire logic [1:0] op_fail,
    input wire logic [1:0] op_halted,
    input wire logic [1:0] op_go,
    input wire logic [7:0] status_two_volatile,
    input wire logic [7:0] config_one_persistent,
    input wire fscr_pkg::fscr_live_t live_cfg,
    input wire logic busy_flag,
    input wire logic write_permit_latch
);
    import fscr_pkg::*;
    // ------------------------------------------------------------------
    // All checks run on the core clock and rest while reset is low.
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_reserved_zero: assert property ((status_two_volatile & 8'h9c) == 8'h00)
        else $error("Reserved status bits not zero");
    a_prog_fail_set: assert property (op_fail[0] |=> status_two_volatile[5])
        else $error("Program failure not flagged");
    a_erase_fail_set: assert property (op_fail[1] |=> status_two_volatile[6])
        else $error("Erase failure not flagged");
    a_prot_erase_fail: assert property (op_req[1] && op_prot_hit[1] && write_permit_latch && !busy_flag
        |=> status_two_volatile[6] && op_go == 2'h0) else $error("Protected erase not refused");
    // A flag may only drop after a finished frame, since only a command clears it.
    a_fail_clear_link: assert property ($fell(status_two_volatile[6]) || $fell(status_two_volatile[5])
        |-> $past(cs_b, 2) && cs_b) else $error("Failure flag dropped without a command");
    a_busy_on_fail: assert property ((|status_two_volatile[6:5]) |-> busy_flag)
        else $error("Busy low while failure flagged");
    a_go_needs_permit: assert property ((|op_go) |-> $past(write_permit_latch) && !$past(busy_flag))
        else $error("Start granted without permit");
    a_halt_follow: assert property ($changed(op_halted) |-> ##[1:3] status_two_volatile[1:0] == op_halted)
        else $error("Suspend bits do not follow engine");
    a_otp_bits_keep: assert property ((($past(config_one_persistent) & ~config_one_persistent) & 8'h3d) == 8'h00)
        else $error("One-time bit cleared");
    a_reg_lock_freeze: assert property (config_one_persistent[0] |=> $stable(config_one_persistent))
        else $error("Locked register changed");
    a_soft_reload: assert property (soft_reset_req |-> ##[1:3] live_cfg.four_lane == config_one_persistent[1])
        else $error("Four-lane default not reloaded");
    c_erase_go: cover property (op_go[1]);
    c_erase_fail: cover property (status_two_volatile[6]);
    c_reg_locked: cover property (config_one_persistent[0]);
endmodule : fscr_regs_props

bind fscr_regs fscr_regs_props fscr_regs_props_inst (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .soft_reset_req(soft_reset_req), .op_req(op_req),
    .op_prot_hit(op_prot_hit), .op_fail(op_fail), .op_halted(op_halted), .op_go(op_go),
    .status_two_volatile(status_two_volatile), .config_one_persistent(config_one_persistent),
    .live_cfg(live_cfg), .busy_flag(busy_flag), .write_permit_latch(write_permit_latch)
);

// ===== sim/fscr_spi_host.sv
// Serial host model that frames register commands to the bank.
`timescale 1ns/1ns
module fscr_spi_host (
    output logic sclk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // The link clock rests low between frames, so the bank never sees stray edges.
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end
    // Sends n bits MSB first at a 32 ns period and captures the last byte.
    task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx, output logic oe_all);
        rx = 8'h00;
        oe_all = 1'b1;
        #5;
        cs_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi = tx[i];
            #16;
            if (i < 8) begin
                rx = {rx[6:0], miso};
                oe_all = oe_all & miso_oe;
            end
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
        end
        #16;
        cs_b = 1'b1;
        mosi = ~mosi; // A released line shows the inverse of its last bit.
        #400;
    endtask : xfer
endmodule : fscr_spi_host

// ===== sim/test_fscr_regs.sv
// Self-checking bench for the flash status and configuration register bank.
`timescale 1ns/1ns
module test_fscr_regs;
    import fscr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic soft_reset_req = 1'b0;
    logic engine_busy = 1'b0;
    logic [2:0] protection_scheme_select = 3'h0;
    logic [3:0] op_region_idx = 4'h0;
    logic [1:0] op_req = 2'h0, op_prot_hit = 2'h0, op_region_hit = 2'h0, op_fail = 2'h0, op_done = 2'h0;
    logic [1:0] op_halted = 2'h0;
    logic sclk, cs_b, mosi, miso, miso_oe, busy_flag, write_permit_latch;
    logic [1:0] op_go;
    logic [7:0] status_two_volatile, config_one_persistent;
    fscr_live_t live_cfg;
    int errors = 0;
    int checked = 0;
    always #5 clk = ~clk;
    fscr_regs fscr_regs_inst (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .soft_reset_req(soft_reset_req), .protection_scheme_select(protection_scheme_select),
        .engine_busy(engine_busy), .op_req(op_req), .op_prot_hit(op_prot_hit), .op_region_hit(op_region_hit),
        .op_region_idx(op_region_idx), .op_fail(op_fail), .op_done(op_done), .op_halted(op_halted),
        .op_go(op_go), .status_two_volatile(status_two_volatile), .config_one_persistent(config_one_persistent),
        .live_cfg(live_cfg), .busy_flag(busy_flag), .write_permit_latch(write_permit_latch)
    );
    fscr_spi_host fscr_spi_host_inst (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic send(input logic [39:0] tx, input int n);
        logic [7:0] rx;
        logic oe;
        fscr_spi_host_inst.xfer(tx, n, rx, oe);
    endtask : send
    task automatic read_sr2(input logic [7:0] exp);
        logic [7:0] rx;
        logic oe;
        fscr_spi_host_inst.xfer({24'h0, OPC_READ_STATUS_TWO, 8'h00}, 16, rx, oe);
        check("status two short read", rx, exp);
        check("status two drive", {7'h0, oe}, 8'h01);
        fscr_spi_host_inst.xfer({OPC_READ_ANY_REG, ADDR_STATUS_TWO_VOLATILE, 8'h00}, 40, rx, oe);
        check("status two any read", rx, exp);
        check("status two port", status_two_volatile, exp);
    endtask : read_sr2
    task automatic check_cfg(input logic [7:0] exp);
        logic [7:0] rx;
        logic oe;
        fscr_spi_host_inst.xfer({OPC_READ_ANY_REG, ADDR_CONFIG_ONE_PERSISTENT, 8'h00}, 40, rx, oe);
        check("config any read", rx, exp);
        check("config port", config_one_persistent, exp);
    endtask : check_cfg
    // Writes always go behind a permit frame, as the host must.
    task automatic write_cfg(input logic [7:0] data, input logic any);
        send({32'h0, OPC_WRITE_PERMIT}, 8);
        check("permit latch", {7'h0, write_permit_latch}, 8'h01);
        if (any)
            send({OPC_WRITE_ANY_REG, ADDR_CONFIG_ONE_PERSISTENT, data}, 40);
        else
            send({16'h0, OPC_WRITE_REGS, 8'h00, data}, 24);
    endtask : write_cfg
    task automatic soft_pulse();
        @(negedge clk);
        soft_reset_req = 1'b1;
        @(negedge clk);
        soft_reset_req = 1'b0;
        repeat (3) @(negedge clk);
    endtask : soft_pulse
    // One engine request, then the grant, the flag, busy, and the clear.
    task automatic fail_case(input logic [1:0] req, prot, rhit, fail, exp_go, input logic [7:0] exp_sr2);
        send({32'h0, OPC_WRITE_PERMIT}, 8);
        @(negedge clk);
        op_req = req;
        op_prot_hit = prot;
        op_region_hit = rhit;
        op_fail = fail;
        @(negedge clk);
        check("start grant", {6'h0, op_go}, {6'h0, exp_go});
        op_req = 2'h0;
        op_prot_hit = 2'h0;
        op_region_hit = 2'h0;
        op_fail = 2'h0;
        read_sr2(exp_sr2);
        check("busy with flag", {7'h0, busy_flag}, {7'h0, |exp_sr2});
        send({32'h0, OPC_CLEAR_STATUS}, 8);
        read_sr2(8'h00);
    endtask : fail_case
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        read_sr2(8'h00);
        check_cfg(8'h00);
        check("live copies", live_cfg, 8'h00);
    endtask : t_reset
    task automatic t_config();
        write_cfg(8'hff, 1'b0);
        check_cfg(8'h7e);
        soft_pulse();
        check("live reload", live_cfg, 8'h7e);
        send({OPC_WRITE_ANY_REG, ADDR_CONFIG_ONE_PERSISTENT, 8'h00}, 40);
        check_cfg(8'h7e);
        write_cfg(8'h00, 1'b1);
        check_cfg(8'h3c);
        soft_pulse();
        check("live reload two", live_cfg, 8'h3c);
        send({32'h0, OPC_WRITE_PERMIT}, 8);
        send({OPC_WRITE_ANY_REG, ADDR_STATUS_TWO_VOLATILE, 8'hff}, 40);
        read_sr2(8'h00);
    endtask : t_config
    task automatic t_fail();
        fail_case(2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 8'h20);
        fail_case(2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 8'h40);
        fail_case(2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 8'h40);
        fail_case(2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 8'h20);
        fail_case(2'h3, 2'h0, 2'h0, 2'h0, 2'h2, 8'h00);
    endtask : t_fail
    task automatic t_suspend();
        @(negedge clk);
        op_halted = 2'h3;
        read_sr2(8'h03);
        @(negedge clk);
        op_halted = 2'h1;
        read_sr2(8'h01);
        @(negedge clk);
        op_halted = 2'h0;
        read_sr2(8'h00);
    endtask : t_suspend
    task automatic t_reg_lock();
        @(negedge clk);
        protection_scheme_select = 3'h7;
        write_cfg(8'h3d, 1'b1);
        check_cfg(8'h3d);
        write_cfg(8'h3f, 1'b0);
        check_cfg(8'h3d);
    endtask : t_reg_lock
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        t_reset();
        t_config();
        t_fail();
        t_suspend();
        t_reg_lock();
        final_report();
    end
endmodule : test_fscr_regs
